// ---- ppp_pkg.sv ----
// constants of the parallel programming port
package ppp_pkg;

  // ************************************************************
  // action select coding on the load strobe
  // ************************************************************
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;

  // ************************************************************
  // command bytes
  // ************************************************************
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE = 8'h03;

  // ************************************************************
  // select pair {secondary, primary} codes
  // ************************************************************
  localparam logic [1:0] SEL_FUSE_LO = 2'h0;
  localparam logic [1:0] SEL_WR_FUSE_HI = 2'h1;
  localparam logic [1:0] SEL_FUSE_EXT = 2'h2;
  localparam logic [1:0] SEL_RD_LOCK = 2'h1;
  localparam logic [1:0] SEL_RD_FUSE_HI = 2'h3;

  // ************************************************************
  // geometry, reset values, identity
  // ************************************************************
  localparam int FLASH_PAGE_WORDS = 128;
  localparam int EE_PAGE_BYTES = 8;
  localparam logic [7:0] FUSE_LO_RST = 8'hFF;
  localparam logic [7:0] FUSE_HI_RST = 8'hFF;
  localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  // identity bytes: arbitrary values
  localparam logic [7:0] SIG_BYTE0 = 8'h5A;
  localparam logic [7:0] SIG_BYTE1 = 8'hA5;
  localparam logic [7:0] SIG_BYTE2 = 8'h3C;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_WLRH_NS = 3700000;
  localparam int BUSY_CYCLES = (T_WLRH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ---- ppp_port.sv ----
// device side command, address and data loading of the parallel programming port
// Operation
// - command strobe loads command byte
// - address strobe loads low or high address
// - data strobe loads low or high data
// - page latch copies data into buffer
// - low bits word, high bits page
// - program strobe starts page write, busy
// - no-op command blocks program strobe
// - EEPROM page write sequence and program
// - flash read drives low/high byte
// - EEPROM read drives addressed byte
// - fuse write selects low/high/extended
// - lock write programs zero bits
// - lock bits return unprogrammed only on lock erase or reset
// - fuse and lock bits readback
// - signature byte read by low address
// - primary select high gives calibration byte
// - ready flag low while busy
// - data bus driven only while enabled
// - command and address held until reload
module ppp_port #(
  parameter int FLASH_PAGE_WORDS = ppp_pkg::FLASH_PAGE_WORDS,
  parameter int EE_PAGE_BYTES = ppp_pkg::EE_PAGE_BYTES,
  parameter int BUSY_CYCLES = ppp_pkg::BUSY_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // programmer pins
  input wire logic load_strobe,
  input wire logic page_latch_strobe,
  input wire logic wr_n,
  input wire logic oe_n,
  input wire logic action_select_hi,
  input wire logic action_select_lo,
  input wire logic byte_select_primary,
  input wire logic byte_select_secondary,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic ready_busy_flag,
  // memory array side
  output logic [15:0] mem_addr,
  input wire logic [15:0] flash_rd_word,
  input wire logic [7:0] ee_rd_byte,
  input wire logic [7:0] osc_cal,
  input wire logic lock_erase,
  output logic prog_start,
  output logic [7:0] prog_cmd,
  output logic [8:0] prog_page,
  input wire logic [6:0] buf_rd_idx,
  output logic [15:0] buf_rd_data,
  // nonvolatile bits
  output logic [7:0] fuse_lo,
  output logic [7:0] fuse_hi,
  output logic [7:0] fuse_ext,
  output logic [7:0] lock_bits
);

  localparam int FW = $clog2(FLASH_PAGE_WORDS);
  localparam int EW = $clog2(EE_PAGE_BYTES);
  localparam int CW = $clog2(BUSY_CYCLES + 1);

  // elaboration checks; the busy check keeps a_busy_start meaningful
  if (FLASH_PAGE_WORDS < 2 || FLASH_PAGE_WORDS > 128 || (1 << FW) != FLASH_PAGE_WORDS) begin
    $error("flash page must be a power of two up to 128 words");
  end
  if (EE_PAGE_BYTES < 2 || EE_PAGE_BYTES > 128 || (1 << EW) != EE_PAGE_BYTES) begin
    $error("eeprom page must be a power of two up to 128 bytes");
  end
  if (BUSY_CYCLES < 5) begin
    $error("busy time must be at least five cycles");
  end

  // ************************************************************
  // strobe edges
  // ************************************************************
  logic load_q, page_latch_strobe_q, wr_q;
  logic load_rise, page_latch_strobe_rise, wr_fall;
  logic [1:0] act, sel;

  assign load_rise = load_strobe && !load_q;
  assign page_latch_strobe_rise = page_latch_strobe && !page_latch_strobe_q;
  assign wr_fall = !wr_n && wr_q;
  assign act = {action_select_hi, action_select_lo};
  assign sel = {byte_select_secondary, byte_select_primary};

  // ************************************************************
  // state
  // ************************************************************
  logic [7:0] cmd, addr_lo, addr_hi, data_lo, data_hi;
  logic [7:0] next_cmd, next_addr_lo, next_addr_hi, next_data_lo, next_data_hi;
  logic [7:0] next_fuse_lo, next_fuse_hi, next_fuse_ext, next_lock_bits;
  logic [7:0] next_prog_cmd, next_data_out;
  logic [8:0] next_prog_page;
  logic [CW-1:0] busy_cnt, next_busy_cnt;
  logic next_prog_start, write_cmd, read_cmd, wr_go;
  logic [15:0] flash_buf [FLASH_PAGE_WORDS];
  logic [7:0] ee_buf [EE_PAGE_BYTES];

  assign write_cmd = cmd == ppp_pkg::CMD_WR_FLASH || cmd == ppp_pkg::CMD_WR_EE
    || cmd == ppp_pkg::CMD_WR_FUSE || cmd == ppp_pkg::CMD_WR_LOCK;
  assign read_cmd = cmd == ppp_pkg::CMD_RD_FLASH || cmd == ppp_pkg::CMD_RD_EE
    || cmd == ppp_pkg::CMD_RD_FUSE || cmd == ppp_pkg::CMD_RD_SIG;
  // a read or no-op command, or a running write, blocks any new write
  assign wr_go = wr_fall && write_cmd && !read_cmd && busy_cnt == '0;
  assign mem_addr = {addr_hi, addr_lo};
  assign ready_busy_flag = busy_cnt == '0;
  assign data_oe_n = oe_n;

  always_comb begin
    next_cmd = cmd;
    next_addr_lo = addr_lo;
    next_addr_hi = addr_hi;
    next_data_lo = data_lo;
    next_data_hi = data_hi;
    next_fuse_lo = fuse_lo;
    next_fuse_hi = fuse_hi;
    next_fuse_ext = fuse_ext;
    next_lock_bits = lock_bits;
    next_prog_cmd = prog_cmd;
    next_prog_page = prog_page;
    next_prog_start = 1'b0;
    next_busy_cnt = busy_cnt;
    // held values change only on an explicit reload
    if (load_rise) begin
      case (act)
        ppp_pkg::ACT_CMD: next_cmd = data_in;
        ppp_pkg::ACT_ADDR: begin
          if (byte_select_primary) begin
            next_addr_hi = data_in;
          end else begin
            next_addr_lo = data_in;
          end
        end
        ppp_pkg::ACT_DATA: begin
          if (byte_select_primary) begin
            next_data_hi = data_in;
          end else begin
            next_data_lo = data_in;
          end
        end
        ppp_pkg::ACT_IDLE: next_cmd = cmd;
        default: next_cmd = cmd;
      endcase
    end
    if (busy_cnt != '0) begin
      next_busy_cnt = busy_cnt - 1'b1;
    end
    if (wr_go && !(cmd == ppp_pkg::CMD_WR_FUSE && sel == 2'h3)) begin
      next_busy_cnt = CW'(BUSY_CYCLES);
      next_prog_start = 1'b1;
      next_prog_cmd = cmd;
      // page number takes the low address bits above the word index
      if (cmd == ppp_pkg::CMD_WR_EE) begin
        next_prog_page = 9'(mem_addr >> EW);
      end else begin
        next_prog_page = 9'(mem_addr >> FW);
      end
      case (cmd)
        ppp_pkg::CMD_WR_FUSE: begin
          case (sel)
            ppp_pkg::SEL_FUSE_LO: next_fuse_lo = data_lo;
            ppp_pkg::SEL_WR_FUSE_HI: next_fuse_hi = data_lo;
            ppp_pkg::SEL_FUSE_EXT: next_fuse_ext = data_lo;
            default: next_fuse_lo = fuse_lo;
          endcase
        end
        ppp_pkg::CMD_WR_LOCK: next_lock_bits = lock_bits & data_lo;
        default: next_lock_bits = lock_bits;
      endcase
    end
    if (lock_erase) begin
      next_lock_bits = ppp_pkg::LOCK_RST;
    end
  end

  // ************************************************************
  // read data mux; registered so data_out never glitches
  // ************************************************************
  always_comb begin
    next_data_out = data_out;
    if (!oe_n) begin
      case (cmd)
        ppp_pkg::CMD_RD_FLASH:
          next_data_out = byte_select_primary ? flash_rd_word[15:8] : flash_rd_word[7:0];
        ppp_pkg::CMD_RD_EE: next_data_out = ee_rd_byte;
        ppp_pkg::CMD_RD_FUSE: begin
          case (sel)
            ppp_pkg::SEL_FUSE_LO: next_data_out = fuse_lo;
            ppp_pkg::SEL_RD_FUSE_HI: next_data_out = fuse_hi;
            ppp_pkg::SEL_FUSE_EXT: next_data_out = fuse_ext;
            default: next_data_out = lock_bits;
          endcase
        end
        ppp_pkg::CMD_RD_SIG: begin
          if (byte_select_primary) begin
            next_data_out = osc_cal;
          end else begin
            case (addr_lo)
              8'h00: next_data_out = ppp_pkg::SIG_BYTE0;
              8'h01: next_data_out = ppp_pkg::SIG_BYTE1;
              8'h02: next_data_out = ppp_pkg::SIG_BYTE2;
              default: next_data_out = 8'hFF;
            endcase
          end
        end
        default: next_data_out = 8'hFF;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      load_q <= 1'b0;
      page_latch_strobe_q <= 1'b0;
      wr_q <= 1'b1;
      cmd <= ppp_pkg::CMD_NOP;
      addr_lo <= 8'h00;
      addr_hi <= 8'h00;
      data_lo <= 8'hFF;
      data_hi <= 8'hFF;
      fuse_lo <= ppp_pkg::FUSE_LO_RST;
      fuse_hi <= ppp_pkg::FUSE_HI_RST;
      fuse_ext <= ppp_pkg::FUSE_EXT_RST;
      lock_bits <= ppp_pkg::LOCK_RST;
      prog_cmd <= ppp_pkg::CMD_NOP;
      prog_page <= 9'h000;
      prog_start <= 1'b0;
      busy_cnt <= '0;
      data_out <= 8'h00;
    end else begin
      load_q <= load_strobe;
      page_latch_strobe_q <= page_latch_strobe;
      wr_q <= wr_n;
      cmd <= next_cmd;
      addr_lo <= next_addr_lo;
      addr_hi <= next_addr_hi;
      data_lo <= next_data_lo;
      data_hi <= next_data_hi;
      fuse_lo <= next_fuse_lo;
      fuse_hi <= next_fuse_hi;
      fuse_ext <= next_fuse_ext;
      lock_bits <= next_lock_bits;
      prog_cmd <= next_prog_cmd;
      prog_page <= next_prog_page;
      prog_start <= next_prog_start;
      busy_cnt <= next_busy_cnt;
      data_out <= next_data_out;
    end
  end

  // ************************************************************
  // page buffers; contents need no reset
  // ************************************************************
  always_ff @(posedge clk) begin
    if (page_latch_strobe_rise && cmd == ppp_pkg::CMD_WR_FLASH && byte_select_primary) begin
      flash_buf[addr_lo[FW-1:0]] <= {data_hi, data_lo};
    end
    if (page_latch_strobe_rise && cmd == ppp_pkg::CMD_WR_EE) begin
      ee_buf[addr_lo[EW-1:0]] <= data_lo;
    end
    if (!rst_n) begin
      buf_rd_data <= 16'h0000;
    end else if (prog_cmd == ppp_pkg::CMD_WR_EE) begin
      buf_rd_data <= {8'h00, ee_buf[buf_rd_idx[EW-1:0]]};
    end else begin
      buf_rd_data <= flash_buf[buf_rd_idx[FW-1:0]];
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_load(logic [1:0] a);
    load_rise && act == a;
  endsequence

  sequence s_prog_go;
    wr_go && cmd != ppp_pkg::CMD_WR_FUSE;
  endsequence

  a_cmd_capture: assert property (s_load(ppp_pkg::ACT_CMD) |=> cmd == $past(data_in))
    else $error("command byte not captured");
  a_addr_hi_load: assert property (s_load(ppp_pkg::ACT_ADDR) && byte_select_primary
    |=> addr_hi == $past(data_in) && $stable(addr_lo))
    else $error("high address byte not captured");
  a_data_lo_load: assert property (s_load(ppp_pkg::ACT_DATA) && !byte_select_primary
    |=> data_lo == $past(data_in) && $stable(data_hi))
    else $error("low data byte not captured");
  a_idle_action: assert property (s_load(ppp_pkg::ACT_IDLE)
    |=> $stable(cmd) && $stable(addr_lo) && $stable(data_lo))
    else $error("idle load changed state");
  a_busy_start: assert property (s_prog_go |=> prog_start ##1 !ready_busy_flag [*4])
    else $error("program strobe did not go busy");
  a_wr_blocked: assert property (wr_fall && (!ready_busy_flag || read_cmd)
    |=> !prog_start)
    else $error("program strobe accepted while blocked");
  a_lock_monotone: assert property (!lock_erase |=> ($past(lock_bits) | ~lock_bits) == 8'hFF)
    else $error("lock bit returned to unprogrammed");
  a_sig_read: assert property (!oe_n && cmd == ppp_pkg::CMD_RD_SIG && !byte_select_primary
    && addr_lo == 8'h01 |=> data_out == ppp_pkg::SIG_BYTE1)
    else $error("wrong signature byte");
  a_cal_read: assert property (!oe_n && cmd == ppp_pkg::CMD_RD_SIG && byte_select_primary
    |=> data_out == $past(osc_cal))
    else $error("calibration byte not driven");
  a_lock_read: assert property (!oe_n && cmd == ppp_pkg::CMD_RD_FUSE
    && sel == ppp_pkg::SEL_RD_LOCK |=> data_out == $past(lock_bits))
    else $error("lock bits not driven");

endmodule

// ---- ppp_array_model.sv ----
// memory array stand-in that answers the port's read address
module ppp_array_model (
  // address from the port
  input wire logic [15:0] mem_addr,
  // read data back to the port
  output logic [15:0] flash_rd_word,
  output logic [7:0] ee_rd_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  // scrambled so a swapped byte or address half shows up
  assign flash_rd_word = {mem_addr[7:0] ^ 8'hC3, mem_addr[15:8] ^ 8'h5A};
  assign ee_rd_byte = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h96;
endmodule

// ---- ppp_port_test.sv ----
// self-checking bench of the parallel programming port
module ppp_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // signals and reference model
  // ************************************************************
  localparam int BUSY = 8;
  logic clk = 1'b0, rst_n = 1'b0, load_strobe = 1'b0, page_latch_strobe = 1'b0;
  logic wr_n = 1'b1, oe_n = 1'b1, action_select_hi = 1'b1, action_select_lo = 1'b1;
  logic byte_select_primary = 1'b0, byte_select_secondary = 1'b0, lock_erase = 1'b0;
  logic [7:0] data_in = 8'h00, osc_cal = 8'h00;
  logic [6:0] buf_rd_idx = 7'h00;
  logic [7:0] data_out, prog_cmd, ee_rd_byte, fuse_lo, fuse_hi, fuse_ext, lock_bits;
  logic data_oe_n, ready_busy_flag, prog_start;
  logic [15:0] mem_addr, flash_rd_word, buf_rd_data;
  logic [8:0] prog_page;
  logic [7:0] a_lo, a_hi, d_lo, d_hi, m_lock;
  logic [7:0] m_fuse[3];
  logic [7:0] sig[3];
  int miscompares = 0, n_compared = 0, seed = 46, n_starts = 0, n_busy = 0, s0, b0, i;

  ppp_port #(.BUSY_CYCLES(BUSY)) uut (.clk(clk), .rst_n(rst_n), .load_strobe(load_strobe),
    .page_latch_strobe(page_latch_strobe), .wr_n(wr_n), .oe_n(oe_n),
    .action_select_hi(action_select_hi), .action_select_lo(action_select_lo),
    .byte_select_primary(byte_select_primary), .byte_select_secondary(byte_select_secondary),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .ready_busy_flag(ready_busy_flag), .mem_addr(mem_addr), .flash_rd_word(flash_rd_word),
    .ee_rd_byte(ee_rd_byte), .osc_cal(osc_cal), .lock_erase(lock_erase),
    .prog_start(prog_start), .prog_cmd(prog_cmd), .prog_page(prog_page),
    .buf_rd_idx(buf_rd_idx), .buf_rd_data(buf_rd_data), .fuse_lo(fuse_lo),
    .fuse_hi(fuse_hi), .fuse_ext(fuse_ext), .lock_bits(lock_bits));
  ppp_array_model u_array (.mem_addr(mem_addr), .flash_rd_word(flash_rd_word),
    .ee_rd_byte(ee_rd_byte));

  always #2 clk = ~clk;
  // outputs only move on the rising edge, so counting here is race free
  always @(negedge clk) begin
    if (prog_start === 1'b1) n_starts++;
    if (ready_busy_flag === 1'b0) n_busy++;
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic load(input logic [1:0] act, input logic pri, input logic [7:0] d);
    {action_select_hi, action_select_lo} = act;
    byte_select_primary = pri;
    data_in = d;
    load_strobe = 1'b1;
    @(negedge clk);
    load_strobe = 1'b0;
    @(negedge clk);
  endtask
  task automatic latch(input logic pri);
    byte_select_primary = pri;
    page_latch_strobe = 1'b1;
    @(negedge clk);
    page_latch_strobe = 1'b0;
    @(negedge clk);
  endtask
  // with twice set, a second strobe lands while busy and must be ignored
  task automatic prog(input logic [1:0] sel, input int starts, input bit twice);
    s0 = n_starts;
    b0 = n_busy;
    {byte_select_secondary, byte_select_primary} = sel;
    wr_n = 1'b0;
    @(negedge clk);
    wr_n = 1'b1;
    repeat (2) @(negedge clk);
    if (twice) begin
      wr_n = 1'b0;
      @(negedge clk);
      wr_n = 1'b1;
    end
    repeat (BUSY + 4) @(negedge clk);
    check(n_starts - s0, starts);
    check(n_busy - b0, starts * BUSY);
    check(ready_busy_flag, 1'b1);
  endtask
  task automatic rd(input logic [1:0] sel, input logic [7:0] exp);
    {byte_select_secondary, byte_select_primary} = sel;
    oe_n = 1'b0;
    repeat (2) @(negedge clk);
    check(data_oe_n, 1'b0);
    check(data_out, exp);
    oe_n = 1'b1;
    @(negedge clk);
    check(data_oe_n, 1'b1);
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end
  initial begin
    sig = '{ppp_pkg::SIG_BYTE0, ppp_pkg::SIG_BYTE1, ppp_pkg::SIG_BYTE2};
    m_fuse = '{8'hFF, 8'hFF, 8'hFF};
    m_lock = 8'hFF;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    check({fuse_lo, fuse_hi}, 16'hFFFF);
    check({fuse_ext, lock_bits}, 16'hFFFF);
    check(ready_busy_flag, 1'b1);
    a_lo = $random(seed);
    a_hi = $random(seed);
    d_lo = $random(seed);
    d_hi = $random(seed);
    load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_FLASH);
    load(ppp_pkg::ACT_ADDR, 1'b0, a_lo);
    load(ppp_pkg::ACT_DATA, 1'b0, d_lo);
    load(ppp_pkg::ACT_DATA, 1'b1, d_hi);
    latch(1'b1);
    load(ppp_pkg::ACT_ADDR, 1'b1, a_hi);
    load(ppp_pkg::ACT_IDLE, 1'b0, ~a_lo);
    check(mem_addr, {a_hi, a_lo});
    prog(2'h0, 1, 1'b1);
    check(prog_cmd, ppp_pkg::CMD_WR_FLASH);
    check(prog_page, {a_hi, a_lo} >> 7);
    buf_rd_idx = a_lo[6:0];
    repeat (2) @(negedge clk);
    check(buf_rd_data, {d_hi, d_lo});
    load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_NOP);
    prog(2'h0, 0, 1'b0);
    load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_FLASH);
    for (i = 0; i < 2; i++) begin
      a_lo = $random(seed);
      load(ppp_pkg::ACT_ADDR, 1'b0, a_lo);
      rd(2'h0, a_hi ^ 8'h5A);
      rd(2'h1, a_lo ^ 8'hC3);
    end
    prog(2'h0, 0, 1'b0);
    load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_EE);
    rd(2'h0, a_lo ^ a_hi ^ 8'h96);
    d_lo = $random(seed);
    load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_EE);
    load(ppp_pkg::ACT_ADDR, 1'b0, a_lo);
    load(ppp_pkg::ACT_DATA, 1'b0, d_lo);
    latch(1'b0);
    prog(2'h0, 1, 1'b0);
    check(prog_page, {7'h00, a_hi[3:0], a_lo[7:3]});
    buf_rd_idx = {4'h0, a_lo[2:0]};
    repeat (2) @(negedge clk);
    check(buf_rd_data[7:0], d_lo);
    load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_FUSE);
    for (i = 0; i < 4; i++) begin
      d_lo = $random(seed);
      load(ppp_pkg::ACT_DATA, 1'b0, d_lo);
      prog(i[1:0], (i < 3) ? 1 : 0, 1'b0);
      if (i < 3) m_fuse[i] = d_lo;
    end
    check({fuse_lo, fuse_hi}, {m_fuse[0], m_fuse[1]});
    check(fuse_ext, m_fuse[2]);
    load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_LOCK);
    for (i = 0; i < 2; i++) begin
      d_lo = $random(seed);
      load(ppp_pkg::ACT_DATA, 1'b0, d_lo);
      prog(2'h0, 1, 1'b0);
      m_lock = m_lock & d_lo;
      check(lock_bits, m_lock);
    end
    load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_FUSE);
    rd(2'h0, m_fuse[0]);
    rd(2'h3, m_fuse[1]);
    rd(2'h2, m_fuse[2]);
    rd(2'h1, m_lock);
    lock_erase = 1'b1;
    @(negedge clk);
    lock_erase = 1'b0;
    @(negedge clk);
    check(lock_bits, 8'hFF);
    osc_cal = $random(seed);
    load(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_SIG);
    for (i = 0; i < 3; i++) begin
      load(ppp_pkg::ACT_ADDR, 1'b0, i[7:0]);
      rd(2'h0, sig[i]);
    end
    rd(2'h1, osc_cal);
    results();
  end
endmodule
